// ===== rssc_sequencer.sv
// How it works
// - Low on the power-on reset input holds the whole block in reset.
// - Ready status bit 7 rises once register access is allowed.
// - After reset, an alignment pulse phase-aligns reference and output clocks.
// - Pin 3 level picks I2C or SPI host port mode.
// - Pins 1 and 0 pick the master clock rate.
// - Code 3 means 24.576 MHz; codes 0 to 2 are reserved.
// - Undriven pins 0 to 5 read low, pins 6 to 11 read high.
// - Boot from default or one-time config, then accept host writes.
// - Host-written config is volatile and cleared by reset.
// - Status is readable through the same serial host port.
// - SPI read data leaves on serial out; in I2C it is address select.
// - SPI select is active low; in I2C it is address select.
// - Released pins gate precision outputs and post-divider clock edges.
module rssc_sequencer #(
    parameter int STRAP_CYCLES = rssc_pkg::STRAP_WINDOW_CYC,
    parameter int PINS = rssc_pkg::PIN_COUNT
) (
    input wire logic core_clk,
    input wire logic reset,
    input wire logic powerOnReset_n,
    input wire logic testEnable,
    input wire logic [PINS-1:0] generalPinIn,
    input wire logic [PINS-1:0] generalPinDriven,
    input wire logic [PINS-1:0] userPinOut,
    input wire logic [PINS-1:0] userPinOe,
    output logic [PINS-1:0] generalPinOut,
    output logic [PINS-1:0] generalPinOe,
    input wire logic otpValid,
    input wire logic [7:0] otpConfig,
    input wire logic [7:0] defaultConfig,
    input wire logic hostWrite,
    input wire logic [7:0] hostWriteData,
    input wire logic hostStatusRead,
    input wire logic hostSelect_n,
    input wire logic hostReadBit,
    input wire logic hostAddr1In,
    input wire logic [1:0] stepEdgeSel,
    output logic [7:0] activeConfig,
    output logic [7:0] statusReg,
    output logic [7:0] statusReadData,
    output logic hostIsI2c,
    output logic [1:0] masterClockSel,
    output logic masterClockValid,
    output logic alignPulse,
    output logic testModeActive,
    output logic host_serial_out_addr1,
    output logic host_serial_out_addr1_oe,
    output logic [1:0] i2cAddrSel,
    output logic [3:0] precisionOutEnable,
    output logic [1:0] postDivRun
);
    localparam int CW = $clog2(STRAP_CYCLES + 1);
    localparam logic [CW-1:0] STRAP_LAST = CW'(STRAP_CYCLES - 1);
    localparam logic [4:0] ALIGN_LAST = 5'(rssc_pkg::ALIGN_CYC - 1);

    logic inReset;
    logic [PINS-1:0] pinLevel;
    logic [PINS-1:0] padOut;
    logic [PINS-1:0] padOe;

    rssc_pkg::rssc_state_type state_q;
    rssc_pkg::rssc_state_type state_d;
    logic [CW-1:0] count_q;
    logic [CW-1:0] count_d;
    logic [4:0] align_q;
    logic [4:0] align_d;
    logic mode_q;
    logic mode_d;
    logic [1:0] mclk_q;
    logic [1:0] mclk_d;
    logic [7:0] config_q;
    logic [7:0] config_d;
    logic [7:0] rdata_q;
    logic [7:0] rdata_d;
    logic alignP_q;
    logic alignP_d;
    logic test_q;
    logic test_d;
    logic so_q;
    logic so_d;
    logic soOe_q;
    logic soOe_d;
    logic [1:0] asel_q;
    logic [1:0] asel_d;
    logic [3:0] precEn_q;
    logic [3:0] precEn_d;
    logic [1:0] divRun_q;
    logic [1:0] divRun_d;
    logic [1:0] ctrlPrev_q;
    logic [1:0] ctrlPrev_d;
    logic released;
    logic ready;

    // Both the external pin and the core reset force the sequence back
    assign inReset = reset | ~powerOnReset_n;
    assign released = (state_q == rssc_pkg::RSSC_ALIGN) || (state_q == rssc_pkg::RSSC_RUN);
    assign ready = (state_q == rssc_pkg::RSSC_RUN);

    genvar gi;
    generate
        for (gi = 0; gi < PINS; gi++) begin : g_pin
            rssc_pin_cell #(
                .PULL_HIGH(gi > rssc_pkg::PULLDOWN_LAST)
            ) u_cell (
                .core_clk(core_clk),
                .reset(inReset),
                .padIn(generalPinIn[gi]),
                .padDriven(generalPinDriven[gi]),
                .userOut(userPinOut[gi]),
                .userOe(userPinOe[gi]),
                .released(released),
                .pinLevel(pinLevel[gi]),
                .padOut(padOut[gi]),
                .padOe(padOe[gi])
            );
        end
    endgenerate

    always_comb begin
        state_d = state_q;
        count_d = count_q;
        align_d = align_q;
        mode_d = mode_q;
        mclk_d = mclk_q;
        alignP_d = 1'b0;
        unique case (state_q)
            rssc_pkg::RSSC_HOLD: begin
                count_d = '0;
                state_d = rssc_pkg::RSSC_STRAP;
            end
            rssc_pkg::RSSC_STRAP: begin
                count_d = count_q + CW'(1);
                if (count_q == STRAP_LAST) begin
                    // Single capture at window end; later pin activity is ignored
                    mode_d = pinLevel[rssc_pkg::PIN_MODE];
                    mclk_d = {pinLevel[rssc_pkg::PIN_MCLK_HI],
                              pinLevel[rssc_pkg::PIN_MCLK_LO]};
                    align_d = '0;
                    state_d = rssc_pkg::RSSC_ALIGN;
                end
            end
            rssc_pkg::RSSC_ALIGN: begin
                // Outputs are realigned to the reference before access opens
                alignP_d = 1'b1;
                align_d = align_q + 5'h01;
                if (align_q == ALIGN_LAST) begin
                    state_d = rssc_pkg::RSSC_RUN;
                end
            end
            rssc_pkg::RSSC_RUN: begin
                state_d = rssc_pkg::RSSC_RUN;
            end
        endcase
    end

    always_comb begin
        config_d = config_q;
        // Boot source picked in the one hold cycle, before the strap window opens
        if (state_q == rssc_pkg::RSSC_HOLD) begin
            config_d = otpValid ? otpConfig : defaultConfig;
        end else if (ready && hostWrite) begin
            config_d = hostWriteData;
        end
        // Status reads share the host port with configuration writes
        rdata_d = hostStatusRead ? statusReg : rdata_q;
        test_d = testEnable;
        // In SPI the pin returns read data while selected; in I2C it only listens
        so_d = hostReadBit;
        soOe_d = ready && !mode_q && !hostSelect_n;
        // In I2C both host pins only listen, and pick the device address
        asel_d = mode_q ? {hostAddr1In, hostSelect_n} : 2'h0;
        ctrlPrev_d = pinLevel[9:8];
        precEn_d = released ? pinLevel[7:4] : 4'h0;
        divRun_d = divRun_q;
        // Each post-divider starts or stops on the chosen edge of its control pin
        for (int k = 0; k < 2; k++) begin
            if (!released) begin
                divRun_d[k] = 1'b0;
            end else if (stepEdgeSel[k] ? (pinLevel[8+k] & ~ctrlPrev_q[k])
                                        : (~pinLevel[8+k] & ctrlPrev_q[k])) begin
                divRun_d[k] = ~divRun_q[k];
            end
        end
    end

    always_ff @(posedge core_clk) begin
        if (inReset) begin
            state_q <= rssc_pkg::RSSC_HOLD;
            count_q <= '0;
            align_q <= '0;
            mode_q <= 1'b0;
            mclk_q <= 2'h0;
            alignP_q <= 1'b0;
            config_q <= rssc_pkg::STATUS_RESET; // Volatile writes lost
            rdata_q <= rssc_pkg::STATUS_RESET;
            test_q <= 1'b0;
            so_q <= 1'b0;
            soOe_q <= 1'b0;
            asel_q <= 2'h0;
            precEn_q <= 4'h0;
            divRun_q <= 2'h0;
            ctrlPrev_q <= 2'h3; // Pull-up level, so no false edge after reset
        end else begin
            state_q <= state_d;
            count_q <= count_d;
            align_q <= align_d;
            mode_q <= mode_d;
            mclk_q <= mclk_d;
            alignP_q <= alignP_d;
            config_q <= config_d;
            rdata_q <= rdata_d;
            test_q <= test_d;
            so_q <= so_d;
            soOe_q <= soOe_d;
            asel_q <= asel_d;
            precEn_q <= precEn_d;
            divRun_q <= divRun_d;
            ctrlPrev_q <= ctrlPrev_d;
        end
    end

    logic [7:0] status_q;
    logic [7:0] status_d;
    logic mcValid_q;
    logic mcValid_d;

    always_comb begin
        status_d = {ready, 4'h0, mode_q, mclk_q};
        // Reserved strap codes never report a usable master clock
        mcValid_d = status_d[rssc_pkg::READY_BIT] && (mclk_q == rssc_pkg::MCLK_24M576);
    end

    always_ff @(posedge core_clk) begin
        if (inReset) begin
            status_q <= rssc_pkg::STATUS_RESET;
            mcValid_q <= 1'b0;
        end else begin
            status_q <= status_d;
            mcValid_q <= mcValid_d;
        end
    end

    assign statusReg = status_q;
    assign statusReadData = rdata_q;
    assign activeConfig = config_q;
    assign hostIsI2c = mode_q;
    assign masterClockSel = mclk_q;
    assign masterClockValid = mcValid_q;
    assign alignPulse = alignP_q;
    assign testModeActive = test_q;
    assign host_serial_out_addr1 = so_q;
    assign host_serial_out_addr1_oe = soOe_q;
    assign i2cAddrSel = asel_q;
    assign precisionOutEnable = precEn_q;
    assign postDivRun = divRun_q;
    assign generalPinOut = padOut;
    assign generalPinOe = padOe;

    AST_RESET_HOLD: assert property (@(posedge core_clk)
        !powerOnReset_n |=> (state_q == rssc_pkg::RSSC_HOLD) && !statusReg[7])
        else $error("block not held in reset");
    AST_READY_AFTER_ALIGN: assert property (@(posedge core_clk) disable iff (inReset)
        $rose(state_q == rssc_pkg::RSSC_RUN) |=> statusReg[7])
        else $error("ready not raised after alignment");
    AST_NO_READY_EARLY: assert property (@(posedge core_clk) disable iff (inReset)
        state_q != rssc_pkg::RSSC_RUN |=> !statusReg[7])
        else $error("ready raised early");
    AST_ALIGN_LEN: assert property (@(posedge core_clk) disable iff (inReset)
        $rose(alignPulse) |-> alignPulse [*8] ##1 alignPulse [*8] ##1 !alignPulse)
        else $error("alignment pulse of wrong length");
    AST_STRAP_HOLD: assert property (@(posedge core_clk) disable iff (inReset)
        released && $past(released) |-> $stable(hostIsI2c) && $stable(masterClockSel))
        else $error("strap value changed after latch");
    AST_NO_DRIVE_STRAP: assert property (@(posedge core_clk) disable iff (inReset)
        !released |=> generalPinOe == '0)
        else $error("strap pin driven during window");
    AST_SO_I2C_QUIET: assert property (@(posedge core_clk) disable iff (inReset)
        hostIsI2c |-> !host_serial_out_addr1_oe)
        else $error("serial out driven in I2C mode");
    AST_VOLATILE: assert property (@(posedge core_clk)
        $past(inReset) && !inReset |=> activeConfig == ($past(otpValid) ? $past(otpConfig)
        : $past(defaultConfig)))
        else $error("host config survived reset");
    AST_MCLK_RESERVED: assert property (@(posedge core_clk) disable iff (inReset)
        masterClockSel != rssc_pkg::MCLK_24M576 |=> !masterClockValid)
        else $error("reserved master clock code reported valid");
    AST_HOST_WRITE: assert property (@(posedge core_clk) disable iff (inReset)
        ready && hostWrite |=> activeConfig == $past(hostWriteData))
        else $error("host write not applied");

    COV_READY: cover property (@(posedge core_clk) $rose(statusReg[7]));
    COV_I2C: cover property (@(posedge core_clk) statusReg[7] && hostIsI2c);
    COV_HOST_WR: cover property (@(posedge core_clk) statusReg[7] && hostWrite);
    COV_SPI_READ: cover property (@(posedge core_clk) host_serial_out_addr1_oe);
    COV_DIV_RUN: cover property (@(posedge core_clk) postDivRun == 2'h3);
endmodule

// ===== rssc_pkg.sv
package rssc_pkg;
    localparam int CLK_PERIOD_NS = 50;
    localparam int STRAP_WINDOW_MS = 50;
    localparam int STRAP_WINDOW_CYC = STRAP_WINDOW_MS * 1000000 / CLK_PERIOD_NS;
    localparam int ALIGN_CYC = 16;
    localparam int PIN_COUNT = 12;
    localparam int PULLDOWN_LAST = 5;
    localparam int PIN_MODE = 3;
    localparam int PIN_MCLK_HI = 1;
    localparam int PIN_MCLK_LO = 0;
    localparam int READY_BIT = 7;
    localparam logic [1:0] MCLK_24M576 = 2'h3;
    localparam logic [7:0] STATUS_RESET = 8'h00;
    typedef enum logic [1:0] {
        RSSC_HOLD,
        RSSC_STRAP,
        RSSC_ALIGN,
        RSSC_RUN
    } rssc_state_type;
endpackage

// ===== rssc_pin_cell.sv
module rssc_pin_cell #(
    parameter bit PULL_HIGH = 1'b0
) (
    input wire logic core_clk,
    input wire logic reset,
    input wire logic padIn,
    input wire logic padDriven,
    input wire logic userOut,
    input wire logic userOe,
    input wire logic released,
    output logic pinLevel,
    output logic padOut,
    output logic padOe
);
    logic level_q;
    logic level_d;
    logic out_q;
    logic out_d;
    logic oe_q;
    logic oe_d;

    always_comb begin
        // Internal pull decides an undriven pin
        level_d = padDriven ? padIn : PULL_HIGH;
        // Pin is never driven while it still serves as a strap
        oe_d = released & userOe;
        out_d = userOut;
    end

    always_ff @(posedge core_clk) begin
        if (reset) begin
            level_q <= PULL_HIGH;
            out_q <= 1'b0;
            oe_q <= 1'b0;
        end else begin
            level_q <= level_d;
            out_q <= out_d;
            oe_q <= oe_d;
        end
    end

    assign pinLevel = level_q;
    assign padOut = out_q;
    assign padOe = oe_q;
endmodule

// ===== rssc_host_model.sv
module rssc_host_model #(
    parameter int POR_CYCLES = 8,
    parameter int STRAP_HOLD = 24
) (
    input wire logic core_clk,
    input wire logic porRequest,
    input wire logic testRequest,
    input wire logic strapI2c,
    input wire logic [1:0] strapMclk,
    input wire logic [11:0] lateLevel,
    input wire logic [11:0] devOut,
    input wire logic [11:0] devOe,
    output logic powerOnReset_n,
    output logic testEnable,
    output logic [11:0] padLevel,
    output logic [11:0] padDriven
);
    timeunit 1ns;
    timeprecision 1ps;
    int porCount = 0;
    int sinceRelease = 0;
    logic [11:0] drvLevel;
    logic [11:0] drvEn;
    always @(posedge core_clk) begin
        if (porRequest) porCount <= POR_CYCLES;
        else if (porCount > 0) porCount <= porCount - 1;
        if (!powerOnReset_n) sinceRelease <= 0;
        else if (sinceRelease < STRAP_HOLD) sinceRelease <= sinceRelease + 1;
    end
    always_comb begin
        powerOnReset_n = (porCount == 0);
        // Raised only when the bench asks for the test mode on purpose
        testEnable = testRequest;
        drvEn = 12'h03B;
        drvLevel = {8'h00, strapI2c, 1'b0, strapMclk};
        if (sinceRelease >= STRAP_HOLD) begin
            drvEn = 12'hFFF;
            drvLevel = lateLevel;
        end
        padDriven = devOe | drvEn;
        // Undriven pads show the inverse of the pull, so the pull must come from the device
        padLevel = (devOe & devOut) | (~devOe & drvEn & drvLevel) | (~padDriven & 12'h03F);
    end
endmodule

// ===== tb.sv
module tb;
    timeunit 1ns;
    timeprecision 1ps;
    typedef struct {int kind; logic [11:0] value;} rssc_note_type;
    logic core_clk = 0, reset = 1, porRequest = 0, testRequest = 0, strapI2c = 0, otpValid = 0;
    logic hostWrite = 0, hostStatusRead = 0, hostSelect_n = 1, hostReadBit = 0, hostAddr1 = 1;
    logic [1:0] strapMclk = 0, stepEdgeSel = 0;
    logic [11:0] lateLevel = 0, userPinOut = 0, userPinOe = 0;
    logic [7:0] otpConfig = 0, defaultConfig = 0, hostWriteData = 0;
    logic powerOnReset_n, testEnable, hostIsI2c, masterClockValid, alignPulse, testModeActive;
    logic serialOut, serialOe;
    logic [11:0] padLevel, padDriven, generalPinOut, generalPinOe, got;
    logic [7:0] activeConfig, statusReg, statusReadData;
    logic [1:0] masterClockSel, i2cAddrSel, postDivRun;
    logic [3:0] precisionOutEnable;
    int errors = 0, samples_checked = 0, alignCount = 0;
    rssc_note_type notes[$];
    rssc_note_type cur;

    rssc_host_model rssc_host_model_i (.core_clk(core_clk), .porRequest(porRequest),
        .testRequest(testRequest), .strapI2c(strapI2c), .strapMclk(strapMclk),
        .lateLevel(lateLevel), .devOut(generalPinOut), .devOe(generalPinOe),
        .powerOnReset_n(powerOnReset_n), .testEnable(testEnable), .padLevel(padLevel),
        .padDriven(padDriven));
    rssc_sequencer #(.STRAP_CYCLES(20), .PINS(12)) rssc_sequencer_i (.core_clk(core_clk),
        .reset(reset), .powerOnReset_n(powerOnReset_n), .testEnable(testEnable),
        .generalPinIn(padLevel), .generalPinDriven(padDriven), .userPinOut(userPinOut),
        .userPinOe(userPinOe), .generalPinOut(generalPinOut), .generalPinOe(generalPinOe),
        .otpValid(otpValid), .otpConfig(otpConfig), .defaultConfig(defaultConfig),
        .hostWrite(hostWrite), .hostWriteData(hostWriteData), .hostStatusRead(hostStatusRead),
        .hostSelect_n(hostSelect_n), .hostReadBit(hostReadBit), .hostAddr1In(hostAddr1),
        .stepEdgeSel(stepEdgeSel),
        .activeConfig(activeConfig), .statusReg(statusReg), .statusReadData(statusReadData),
        .hostIsI2c(hostIsI2c), .masterClockSel(masterClockSel),
        .masterClockValid(masterClockValid), .alignPulse(alignPulse),
        .testModeActive(testModeActive), .host_serial_out_addr1(serialOut),
        .host_serial_out_addr1_oe(serialOe), .i2cAddrSel(i2cAddrSel),
        .precisionOutEnable(precisionOutEnable), .postDivRun(postDivRun));

    initial forever #25 core_clk = ~core_clk;
    always @(posedge core_clk) begin
        if (porRequest) alignCount <= 0;
        else if (alignPulse === 1'b1) alignCount <= alignCount + 1;
    end

    function automatic logic [11:0] actual(input int kind);
        case (kind)
            0: return 12'(activeConfig);
            1: return 12'(statusReg);
            2: return 12'(statusReadData);
            3: return 12'({hostIsI2c, masterClockValid, masterClockSel});
            4: return 12'({serialOe, i2cAddrSel});
            5: return 12'(serialOut);
            6: return 12'(precisionOutEnable);
            7: return 12'(postDivRun);
            8: return generalPinOe;
            9: return generalPinOut & generalPinOe;
            10: return 12'(testModeActive);
            default: return 12'(alignCount);
        endcase
    endfunction

    task check_byte(input logic [7:0] g, input logic [7:0] e);
        samples_checked++;
        if (g !== e) begin
            errors++;
            $display("wrong value at %0t: got %h expected %h", $time, g, e);
        end
    endtask
    task check_bits(input logic [11:0] g, input logic [11:0] e);
        samples_checked++;
        if (g !== e) begin
            errors++;
            $display("wrong value at %0t: got %h expected %h", $time, g, e);
        end
    endtask

    always @(negedge core_clk) begin
        while (notes.size() > 0) begin
            cur = notes.pop_front();
            got = actual(cur.kind);
            if (cur.kind < 3) check_byte(got[7:0], cur.value[7:0]);
            else check_bits(got, cur.value);
        end
    end

    task note(input int kind, input logic [11:0] value);
        notes.push_back('{kind, value});
    endtask
    task tick(input int n);
        repeat (n) @(posedge core_clk);
    endtask
    task host_write(input logic [7:0] d);
        @(posedge core_clk);
        // Only the data byte reaches the block; command and address are decoded ahead
        hostWrite <= 1;
        hostWriteData <= d;
        @(posedge core_clk);
        hostWrite <= 0;
        note(0, 12'(d));
    endtask
    task status_read(input logic [7:0] e);
        @(posedge core_clk);
        hostStatusRead <= 1;
        @(posedge core_clk);
        hostStatusRead <= 0;
        note(2, 12'(e));
    endtask
    task boot(input logic i2c, input logic [1:0] mc, input logic otp, input logic [11:0] late);
        int n;
        n = 0;
        @(posedge core_clk);
        strapI2c <= i2c;
        strapMclk <= mc;
        otpValid <= otp;
        lateLevel <= late;
        otpConfig <= 8'($urandom);
        defaultConfig <= 8'($urandom);
        porRequest <= 1;
        @(posedge core_clk);
        porRequest <= 0;
        tick(2);
        note(1, 12'h000);
        tick(10);
        // A write inside the strap window, before ready, must be dropped
        hostWrite <= 1;
        hostWriteData <= 8'h5A;
        @(posedge core_clk);
        hostWrite <= 0;
        while (statusReg[7] !== 1'b1 && n < 200) begin
            @(negedge core_clk);
            n++;
        end
        if (n >= 200) errors++;
        @(posedge core_clk);
        note(1, {4'h0, 1'b1, 4'h0, i2c, mc});
        note(3, {8'h00, i2c, mc == 2'h3, mc});
        note(0, 12'(otp ? otpConfig : defaultConfig));
        note(11, 12'h010);
        note(6, 12'(late[7:4]));
    endtask

    task print_verdict;
        if (errors == 0 && samples_checked > 0) begin
            $display("All tests passed");
        end else begin
            $display("Some tests failed");
        end
        $finish;
    endtask

    initial begin
        #(50 * 4000);
        errors++;
        print_verdict;
    end

    initial begin
        void'($urandom(32'h9C1C));
        tick(10);
        reset <= 0;
        boot(1, 2'h3, 1, 12'h350);
        host_write(8'($urandom));
        host_write(8'($urandom));
        status_read(8'h87);
        tick(3);
        note(4, 12'h003);
        hostAddr1 <= 0;
        hostSelect_n <= 0;
        tick(2);
        note(4, 12'h000);
        hostAddr1 <= 1;
        hostSelect_n <= 1;
        testRequest <= 1;
        tick(2);
        note(10, 12'h001);
        testRequest <= 0;
        stepEdgeSel <= 2'b01;
        lateLevel[8] <= 0;
        tick(4);
        note(7, 12'h000);
        lateLevel[8] <= 1;
        tick(4);
        note(7, 12'h001);
        lateLevel[9] <= 0;
        tick(4);
        note(7, 12'h003);
        userPinOut <= 12'($urandom);
        userPinOe <= 12'($urandom);
        tick(3);
        note(8, userPinOe);
        note(9, userPinOut & userPinOe);
        userPinOe <= 0;
        boot(0, 2'h0, 0, 12'h35B);
        hostSelect_n <= 0;
        hostReadBit <= 1;
        tick(3);
        note(4, 12'h004);
        note(5, 12'h001);
        hostReadBit <= 0;
        tick(2);
        note(5, 12'h000);
        hostSelect_n <= 1;
        tick(3);
        note(4, 12'h000);
        status_read(8'h80);
        tick(2);
        print_verdict;
    end
endmodule
